// ### verilog/ssp_pkg.sv
package ssp_pkg;

  // Serial word and divider widths
  localparam int unsigned WORD_W = 8;
  localparam int unsigned DIV_W  = 8;
  localparam int unsigned NPIN   = 6;
  localparam int unsigned ADDR_W = 8;

  // Pin positions within the six-pin group
  localparam int unsigned PIN_CTRL_A = 0;
  localparam int unsigned PIN_CTRL_B = 1;
  localparam int unsigned PIN_FS     = 2;
  localparam int unsigned PIN_SCK    = 3;
  localparam int unsigned PIN_RXD    = 4;
  localparam int unsigned PIN_TXD    = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PORT_CTL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT_DIR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GPIO_OUT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GPIO_IN  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SER_CFG  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TX0      = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TX1      = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TX2      = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_RX       = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h24;

  // Status register bit positions
  localparam int unsigned ST_TX_FULL = 0;
  localparam int unsigned ST_RX_FULL = 1;
  localparam int unsigned ST_FLAG0   = 2;
  localparam int unsigned ST_FLAG1   = 3;

  // Reset values
  localparam logic [NPIN-1:0]  PIN_RST = 6'h00;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h04;

  // Register selector
  typedef enum logic [3:0] {
    SEL_PORT_CTL = 4'h0,
    SEL_PORT_DIR = 4'h1,
    SEL_GPIO_OUT = 4'h2,
    SEL_GPIO_IN  = 4'h3,
    SEL_SER_CFG  = 4'h4,
    SEL_TX0      = 4'h5,
    SEL_TX1      = 4'h6,
    SEL_TX2      = 4'h7,
    SEL_RX       = 4'h8,
    SEL_STATUS   = 4'h9,
    SEL_NONE     = 4'hF
  } reg_sel_t;

  // Serial configuration word, bit 0 is sync_mode
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [1:0]       flag;
    logic             enable;
    logic             ctrl_b_tx;
    logic             ctrl_a_tx;
    logic             ctrl_b_out;
    logic             ctrl_a_out;
    logic             fs_out;
    logic             sck_out;
    logic             sync_mode;
  } ser_cfg_t;

  localparam int unsigned CFG_W = $bits(ser_cfg_t);

  // APB request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

endpackage

// ### verilog/sync_serial_port_pins.sv
`timescale 1ns/1ps

// Operation
// - Async: control pin A is receive clock
// - Sync: control pin A is tx1 or flag0
// - Async: control pin B is receive frame sync
// - Sync: control pin B is tx2 or flag1
// - Frame sync pin: shared sync, tx-only async
// - Frame sync pin drives internal or accepts external
// - Bit clock pin clocks tx, rx if sync
// - Receive data pin is input, feeds shifter
// - Transmit data pin driven whenever serial enable is set
// - All six pins reset to GPIO inputs
// - GPIO direction register; control selects serial function
// - Stop: inputs ignored, outputs hold level undriven
// - Wait state leaves pins unchanged
module sync_serial_port_pins (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire ssp_pkg::apb_req_t         apb_req,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      stop_req,
  input  wire logic [ssp_pkg::NPIN-1:0]  pin_in,
  output logic [ssp_pkg::NPIN-1:0]       pin_out,
  output logic [ssp_pkg::NPIN-1:0]       pin_oe
);

  localparam int unsigned W = ssp_pkg::WORD_W;
  localparam int unsigned N = ssp_pkg::NPIN;

  typedef struct packed {
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
    logic [N-1:0]                   pin_out;
    logic [N-1:0]                   pin_oe;
    logic [N-1:0]                   port_ctl;
    logic [N-1:0]                   port_dir;
    logic [N-1:0]                   gpio_out;
    logic [N-1:0]                   gpio_in;
    ssp_pkg::ser_cfg_t              cfg;
    logic [2:0][W-1:0]              tx_word;
    logic [2:0][W-1:0]              tx_sh;
    logic                           tx_full;
    logic [3:0]                     tx_cnt;
    logic [W-1:0]                   rx_sh;
    logic [W-1:0]                   rx_word;
    logic                           rx_full;
    logic [3:0]                     rx_cnt;
    logic [ssp_pkg::DIV_W-1:0]      div_cnt;
    logic                           sck_q;
    logic                           fs_q;
    logic [N-1:0]                   s1;
    logic [N-1:0]                   s2;
    logic [N-1:0]                   s3;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Address to register selector
  function automatic ssp_pkg::reg_sel_t reg_decode(input logic [ssp_pkg::ADDR_W-1:0] a);
    case (a)
      ssp_pkg::OFS_PORT_CTL: reg_decode = ssp_pkg::SEL_PORT_CTL;
      ssp_pkg::OFS_PORT_DIR: reg_decode = ssp_pkg::SEL_PORT_DIR;
      ssp_pkg::OFS_GPIO_OUT: reg_decode = ssp_pkg::SEL_GPIO_OUT;
      ssp_pkg::OFS_GPIO_IN:  reg_decode = ssp_pkg::SEL_GPIO_IN;
      ssp_pkg::OFS_SER_CFG:  reg_decode = ssp_pkg::SEL_SER_CFG;
      ssp_pkg::OFS_TX0:      reg_decode = ssp_pkg::SEL_TX0;
      ssp_pkg::OFS_TX1:      reg_decode = ssp_pkg::SEL_TX1;
      ssp_pkg::OFS_TX2:      reg_decode = ssp_pkg::SEL_TX2;
      ssp_pkg::OFS_RX:       reg_decode = ssp_pkg::SEL_RX;
      ssp_pkg::OFS_STATUS:   reg_decode = ssp_pkg::SEL_STATUS;
      default:               reg_decode = ssp_pkg::SEL_NONE;
    endcase
  endfunction

  // Derived strobes and serial events
  ssp_pkg::reg_sel_t sel;
  logic              setup_ph;
  logic              wr_acc;
  logic              rd_acc;
  logic              int_tick;
  logic              int_rise;
  logic              int_fall;
  logic              tx_rise;
  logic              rx_fall;
  logic              rx_fs;
  logic              tx_start;
  logic              run;
  logic [N-1:0]      sync_rise;
  logic [N-1:0]      sync_fall;

  always_comb begin
    sel       = reg_decode(apb_req.paddr);
    setup_ph  = apb_req.psel && !apb_req.penable;
    wr_acc    = apb_req.psel && apb_req.penable && s_q.pready && apb_req.pwrite;
    rd_acc    = apb_req.psel && apb_req.penable && s_q.pready && !apb_req.pwrite;
    run       = s_q.cfg.enable && !stop_req;
    // Edges only from the second and third sync stages
    sync_rise = s_q.s2 & ~s_q.s3;
    sync_fall = ~s_q.s2 & s_q.s3;
    // Internal bit clock from the divider
    int_tick  = run && (s_q.div_cnt == s_q.cfg.div);
    int_rise  = int_tick && !s_q.sck_q;
    int_fall  = int_tick && s_q.sck_q;
    // Transmit clock: internal or bit clock pin
    tx_rise   = s_q.cfg.sck_out ? int_rise : (run && sync_rise[ssp_pkg::PIN_SCK]);
    // Receive clock: shared in sync, control pin A in async
    if (s_q.cfg.sync_mode) begin
      rx_fall = s_q.cfg.sck_out ? int_fall : (run && sync_fall[ssp_pkg::PIN_SCK]);
    end else begin
      rx_fall = s_q.cfg.ctrl_a_out ? int_fall
                                   : (run && sync_fall[ssp_pkg::PIN_CTRL_A]);
    end
    // Receive frame sync: shared pin in sync, control pin B in async
    if (s_q.cfg.sync_mode) begin
      rx_fs = s_q.cfg.fs_out ? s_q.fs_q : s_q.s2[ssp_pkg::PIN_FS];
    end else begin
      rx_fs = s_q.cfg.ctrl_b_out ? s_q.fs_q : s_q.s2[ssp_pkg::PIN_CTRL_B];
    end
    // Transmit frame start: own word ready or far-end sync
    tx_start  = (s_q.tx_cnt <= 4'h1)
              && (s_q.cfg.fs_out ? s_q.tx_full : s_q.s2[ssp_pkg::PIN_FS]);
  end

  // Next state
  always_comb begin
    s_d = s_q;
    // Pin synchronisers, three stages for edge finding
    s_d.s1 = pin_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // Inputs ignored while stopped
    if (!stop_req) begin
      s_d.gpio_in = s_q.s2;
    end

    // APB answer one cycle after setup
    s_d.pready  = setup_ph;
    s_d.pslverr = setup_ph && (sel == ssp_pkg::SEL_NONE);
    if (setup_ph) begin
      case (sel)
        ssp_pkg::SEL_PORT_CTL: s_d.prdata = {26'h0, s_q.port_ctl};
        ssp_pkg::SEL_PORT_DIR: s_d.prdata = {26'h0, s_q.port_dir};
        ssp_pkg::SEL_GPIO_OUT: s_d.prdata = {26'h0, s_q.gpio_out};
        ssp_pkg::SEL_GPIO_IN:  s_d.prdata = {26'h0, s_q.gpio_in};
        ssp_pkg::SEL_SER_CFG:  s_d.prdata = {14'h0, s_q.cfg};
        ssp_pkg::SEL_TX0:      s_d.prdata = {24'h0, s_q.tx_word[0]};
        ssp_pkg::SEL_TX1:      s_d.prdata = {24'h0, s_q.tx_word[1]};
        ssp_pkg::SEL_TX2:      s_d.prdata = {24'h0, s_q.tx_word[2]};
        ssp_pkg::SEL_RX:       s_d.prdata = {24'h0, s_q.rx_word};
        ssp_pkg::SEL_STATUS:   s_d.prdata = {28'h0, s_q.gpio_in[ssp_pkg::PIN_CTRL_B],
                                             s_q.gpio_in[ssp_pkg::PIN_CTRL_A],
                                             s_q.rx_full, s_q.tx_full};
        default:               s_d.prdata = 32'h0;
      endcase
    end

    // Internal divider and bit clock
    if (!run) begin
      s_d.div_cnt = '0;
    end else if (int_tick) begin
      s_d.div_cnt = '0;
      s_d.sck_q   = !s_q.sck_q;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 1'b1;
    end

    // Transmit shifting on bit clock rise
    if (tx_rise) begin
      s_d.fs_q = tx_start && s_q.cfg.fs_out;
      if (s_q.tx_cnt > 4'h1) begin
        for (int k = 0; k < 3; k++) begin
          s_d.tx_sh[k] = {s_q.tx_sh[k][W-2:0], 1'b0};
        end
        s_d.tx_cnt = s_q.tx_cnt - 1'b1;
      end else if (tx_start) begin
        s_d.tx_sh   = s_q.tx_word;
        s_d.tx_cnt  = 4'(W);
        s_d.tx_full = 1'b0;
      end else begin
        s_d.tx_cnt = 4'h0;
      end
    end

    // Receive shifting on bit clock fall
    if (rx_fall) begin
      if (s_q.rx_cnt == 4'h0) begin
        if (rx_fs) begin
          s_d.rx_sh  = {s_q.rx_sh[W-2:0], s_q.s2[ssp_pkg::PIN_RXD]};
          s_d.rx_cnt = 4'(W - 1);
        end
      end else begin
        s_d.rx_sh  = {s_q.rx_sh[W-2:0], s_q.s2[ssp_pkg::PIN_RXD]};
        s_d.rx_cnt = s_q.rx_cnt - 1'b1;
      end
    end

    // Reading the receive word clears its flag
    if (rd_acc && sel == ssp_pkg::SEL_RX) begin
      s_d.rx_full = 1'b0;
    end
    // Word complete: set wins over read clear
    if (rx_fall && s_q.rx_cnt == 4'h1) begin
      s_d.rx_word = {s_q.rx_sh[W-2:0], s_q.s2[ssp_pkg::PIN_RXD]};
      s_d.rx_full = 1'b1;
    end

    // Register writes at the access edge
    if (wr_acc) begin
      case (sel)
        ssp_pkg::SEL_PORT_CTL: s_d.port_ctl = apb_req.pwdata[N-1:0];
        ssp_pkg::SEL_PORT_DIR: s_d.port_dir = apb_req.pwdata[N-1:0];
        ssp_pkg::SEL_GPIO_OUT: s_d.gpio_out = apb_req.pwdata[N-1:0];
        ssp_pkg::SEL_SER_CFG:  s_d.cfg      = apb_req.pwdata[ssp_pkg::CFG_W-1:0];
        ssp_pkg::SEL_TX1:      s_d.tx_word[1] = apb_req.pwdata[W-1:0];
        ssp_pkg::SEL_TX2:      s_d.tx_word[2] = apb_req.pwdata[W-1:0];
        ssp_pkg::SEL_TX0: begin
          s_d.tx_word[0] = apb_req.pwdata[W-1:0];
          s_d.tx_full    = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Pin drive; frozen and undriven while stopped
    if (stop_req) begin
      s_d.pin_oe = '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        s_d.pin_oe[i]  = s_q.port_dir[i];
        s_d.pin_out[i] = s_q.gpio_out[i];
      end
      if (s_q.port_ctl[ssp_pkg::PIN_CTRL_A]) begin
        s_d.pin_oe[ssp_pkg::PIN_CTRL_A] = s_q.cfg.ctrl_a_out;
        if (!s_q.cfg.sync_mode) begin
          s_d.pin_out[ssp_pkg::PIN_CTRL_A] = s_q.sck_q;
        end else begin
          s_d.pin_out[ssp_pkg::PIN_CTRL_A] = s_q.cfg.ctrl_a_tx ? s_q.tx_sh[1][W-1]
                                                              : s_q.cfg.flag[0];
        end
      end
      if (s_q.port_ctl[ssp_pkg::PIN_CTRL_B]) begin
        s_d.pin_oe[ssp_pkg::PIN_CTRL_B] = s_q.cfg.ctrl_b_out;
        if (!s_q.cfg.sync_mode) begin
          s_d.pin_out[ssp_pkg::PIN_CTRL_B] = s_q.fs_q;
        end else begin
          s_d.pin_out[ssp_pkg::PIN_CTRL_B] = s_q.cfg.ctrl_b_tx ? s_q.tx_sh[2][W-1]
                                                              : s_q.cfg.flag[1];
        end
      end
      if (s_q.port_ctl[ssp_pkg::PIN_FS]) begin
        s_d.pin_oe[ssp_pkg::PIN_FS]  = s_q.cfg.fs_out;
        s_d.pin_out[ssp_pkg::PIN_FS] = s_q.fs_q;
      end
      if (s_q.port_ctl[ssp_pkg::PIN_SCK]) begin
        s_d.pin_oe[ssp_pkg::PIN_SCK]  = s_q.cfg.sck_out;
        s_d.pin_out[ssp_pkg::PIN_SCK] = s_q.sck_q;
      end
      if (s_q.port_ctl[ssp_pkg::PIN_RXD]) begin
        s_d.pin_oe[ssp_pkg::PIN_RXD]  = 1'b0;
        s_d.pin_out[ssp_pkg::PIN_RXD] = 1'b0;
      end
      if (s_q.port_ctl[ssp_pkg::PIN_TXD]) begin
        s_d.pin_oe[ssp_pkg::PIN_TXD]  = s_q.cfg.enable;
        s_d.pin_out[ssp_pkg::PIN_TXD] = s_q.tx_sh[0][W-1];
      end
    end
  end

  // State register; all pins come up as GPIO inputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q          <= '0;
      s_q.port_ctl <= ssp_pkg::PIN_RST;
      s_q.port_dir <= ssp_pkg::PIN_RST;
      s_q.cfg.div  <= ssp_pkg::DIV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops; no wait input, wait has no effect
  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign pin_out = s_q.pin_out;
  assign pin_oe  = s_q.pin_oe;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  gpio_reset_a: assert property (disable iff (1'b0) $rose(rstn) |->
    (pin_oe == 6'h00 && s_q.port_ctl == 6'h00))
    else $error("pins not GPIO inputs after reset");
  gpio_dir_a: assert property (!stop_req && s_q.port_ctl == 6'h00 |=>
    pin_oe == $past(s_q.port_dir))
    else $error("GPIO direction not followed");
  rxd_input_a: assert property (s_q.port_ctl[4] |=> !pin_oe[4])
    else $error("receive data pin driven");
  txd_drive_a: assert property (s_q.port_ctl[5] && s_q.cfg.enable && !stop_req
    |=> pin_oe[5] && pin_out[5] == $past(s_q.tx_sh[0][7]))
    else $error("transmit data pin not driven");
  stop_hold_a: assert property (stop_req && $past(stop_req) |->
    pin_oe == 6'h00 && $stable(pin_out))
    else $error("pin changed while stopped");
  sck_drive_a: assert property (s_q.port_ctl[3] && s_q.cfg.sck_out && !stop_req
    |=> pin_oe[3] && pin_out[3] == $past(s_q.sck_q))
    else $error("bit clock pin wrong");
  fs_drive_a: assert property (s_q.port_ctl[2] && s_q.cfg.fs_out && !stop_req
    |=> pin_oe[2] && pin_out[2] == $past(s_q.fs_q))
    else $error("frame sync pin wrong");
  async_rclk_a: assert property (s_q.port_ctl[0] && !s_q.cfg.sync_mode
    && s_q.cfg.ctrl_a_out && !stop_req |=> pin_out[0] == $past(s_q.sck_q))
    else $error("receive clock pin wrong");
  sync_flag_a: assert property (s_q.port_ctl[0] && s_q.cfg.sync_mode
    && !s_q.cfg.ctrl_a_tx && !stop_req |=> pin_out[0] == $past(s_q.cfg.flag[0]))
    else $error("flag zero pin wrong");
  async_rfs_a: assert property (s_q.port_ctl[1] && !s_q.cfg.sync_mode
    && s_q.cfg.ctrl_b_out && !stop_req |=> pin_out[1] == $past(s_q.fs_q))
    else $error("receive frame sync pin wrong");
  sync_flag1_a: assert property (s_q.port_ctl[1] && s_q.cfg.sync_mode
    && !s_q.cfg.ctrl_b_tx && !stop_req |=> pin_out[1] == $past(s_q.cfg.flag[1]))
    else $error("flag one pin wrong");
  apb_answer_a: assert property (apb_req.psel && !apb_req.penable |=> pready)
    else $error("no APB answer");

  frame_tx_c: cover property (tx_rise && tx_start);
  word_rx_c: cover property (rx_fall && s_q.rx_cnt == 4'h1);
  stop_c: cover property ($rose(stop_req) && |pin_oe);
  async_c: cover property (!s_q.cfg.sync_mode && rx_fall);

endmodule

// ### tb/ssp_far_model.sv
`timescale 1ns/1ps

// Far codec: follows or makes the bit clock, sends rx words, captures lanes
module ssp_far_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [5:0] line,
  input  wire logic [5:0] gpio_val,
  input  wire logic [5:0] gpio_en,
  input  wire logic       ext_mode,
  input  wire logic [7:0] rx_word,
  output logic [5:0]      drv,
  output logic [5:0]      drv_en,
  output logic [7:0]      got_tx,
  output logic [7:0]      got_a,
  output logic [7:0]      got_b,
  output logic [3:0]      got_cnt
);
  logic       sck_q = 1'b0;
  logic       fs_q  = 1'b0;
  logic       rx_bit_q;
  logic       prev_q;
  logic [2:0] idx_q;

  // Rx data always ours; clock and frame sync only when we clock the link
  always_comb begin
    drv                          = gpio_val;
    drv_en                       = gpio_en;
    drv[ssp_pkg::PIN_RXD]        = gpio_en[ssp_pkg::PIN_RXD] ? gpio_val[ssp_pkg::PIN_RXD]
                                                             : rx_bit_q;
    drv_en[ssp_pkg::PIN_RXD]     = 1'b1;
    if (ext_mode) begin
      drv[ssp_pkg::PIN_SCK]    = sck_q;
      drv[ssp_pkg::PIN_FS]     = fs_q;
      drv_en[ssp_pkg::PIN_SCK] = 1'b1;
      drv_en[ssp_pkg::PIN_FS]  = 1'b1;
    end
  end

  // Either clock on the line: next rx bit on rise, capture the three lanes on fall
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q   <= 1'b0;
      rx_bit_q <= 1'b0;
      idx_q    <= 3'h0;
      got_cnt  <= 4'h8;
    end else begin
      prev_q <= line[ssp_pkg::PIN_SCK];
      if (line[ssp_pkg::PIN_SCK] && !prev_q) begin
        rx_bit_q <= rx_word[line[ssp_pkg::PIN_FS] ? 3'h7 : idx_q - 3'h1];
        idx_q    <= line[ssp_pkg::PIN_FS] ? 3'h7 : idx_q - 3'h1;
        if (line[ssp_pkg::PIN_FS]) got_cnt <= 4'h0;
      end
      if (!line[ssp_pkg::PIN_SCK] && prev_q && got_cnt < 4'h8) begin
        got_tx  <= {got_tx[6:0], line[ssp_pkg::PIN_TXD]};
        got_a   <= {got_a[6:0], line[ssp_pkg::PIN_CTRL_A]};
        got_b   <= {got_b[6:0], line[ssp_pkg::PIN_CTRL_B]};
        got_cnt <= got_cnt + 4'h1;
      end
    end
  end

  // Our own 400 ns bit clock; it stands low between frames
  // Only the clock and frame sync come from here; the edge process moves the data
  task automatic ext_frame();
    for (int b = 7; b >= 0; b--) begin
      @(posedge clk);
      sck_q <= 1'b1;
      fs_q  <= (b == 7);
      repeat (4) @(posedge clk);
      sck_q <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps

// Bench for the serial pin block against a far codec model
module tb_top;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic        err;
  } row_t;

  logic              clk      = 1'b0;
  logic              rstn     = 1'b0;
  ssp_pkg::apb_req_t apb_req  = '0;
  logic              stop_req = 1'b0;
  logic [5:0]        gpio_val = 6'h00;
  logic [5:0]        gpio_en  = 6'h00;
  logic              ext_mode = 1'b0;
  logic [7:0]        rx_word  = 8'h00;
  logic              tog      = 1'b0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [5:0]        pin_in;
  logic [5:0]        pin_out;
  logic [5:0]        pin_oe;
  logic [5:0]        drv;
  logic [5:0]        drv_en;
  logic [7:0]        got_tx;
  logic [7:0]        got_a;
  logic [7:0]        got_b;
  logic [3:0]        got_cnt;
  logic [31:0]       rd_q;
  logic              err_q;
  int                fail_count = 0;
  int                n_checks   = 0;
  int                n_tog      = 0;
  logic              last0      = 1'b0;
  row_t              rows [7];

  // Clock, and a pattern on lines that nobody drives
  always #25 clk = ~clk;
  always @(posedge clk) tog <= ~tog;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv) | (~pin_oe & ~drv_en & {6{tog}});

  sync_serial_port_pins dut_u (
    .clk(clk), .rstn(rstn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_req(stop_req), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  ssp_far_model far_u (
    .clk(clk), .rstn(rstn), .line(pin_in), .gpio_val(gpio_val), .gpio_en(gpio_en),
    .ext_mode(ext_mode), .rx_word(rx_word), .drv(drv), .drv_en(drv_en),
    .got_tx(got_tx), .got_a(got_a), .got_b(got_b), .got_cnt(got_cnt)
  );

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q  = prdata;
    err_q = pslverr;
    apb_req <= '0;
    if (pready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    @(posedge clk);
  endtask

  // Wait for a frame to start and for all eight bits to be captured
  task automatic wait_frame();
    int   n;
    logic started;
    n = 0;
    while (got_cnt === 4'h8 && n < 100) begin
      @(posedge clk);
      n++;
    end
    started = (got_cnt !== 4'h8);
    while (got_cnt !== 4'h8 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (!started || got_cnt !== 4'h8) begin
      fail_count++;
      wrap_up();
    end
  endtask

  initial begin
    rows = '{'{ssp_pkg::OFS_PORT_CTL, 32'hFFFF_FFC0, 32'h0000_0000, 1'b0},
             '{ssp_pkg::OFS_PORT_DIR, 32'hFFFF_FFFF, 32'h0000_003F, 1'b0},
             '{ssp_pkg::OFS_PORT_DIR, 32'h0000_0015, 32'h0000_0015, 1'b0},
             '{ssp_pkg::OFS_GPIO_OUT, 32'hFFFF_FF2A, 32'h0000_002A, 1'b0},
             '{ssp_pkg::OFS_SER_CFG, 32'hFFFC_0300, 32'h0000_0300, 1'b0},
             '{ssp_pkg::OFS_RX, 32'h0000_00FF, 32'h0000_0000, 1'b0},
             '{8'h30, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(32'(pin_oe), 32'h0);
    apb(1'b0, ssp_pkg::OFS_PORT_CTL, 32'h0);
    check(rd_q, 32'h0);
    apb(1'b0, ssp_pkg::OFS_SER_CFG, 32'h0);
    check(rd_q, 32'h0000_1000);
    // Register table rows: write, read back
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      apb(1'b0, rows[i].addr, 32'h0);
      check(rd_q, rows[i].exp);
      check(32'(err_q), 32'(rows[i].err));
    end
    // General-purpose pins in both directions
    gpio_en  <= 6'h2A;
    gpio_val <= 6'h28;
    repeat (4) @(posedge clk);
    check(32'(pin_oe), 32'h15);
    check(32'(pin_out), 32'h2A);
    apb(1'b0, ssp_pkg::OFS_GPIO_IN, 32'h0);
    check(rd_q, 32'h28);
    // Stop: drivers off, levels kept, inputs frozen
    apb(1'b1, ssp_pkg::OFS_PORT_DIR, 32'h3F);
    repeat (4) @(posedge clk);
    stop_req <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(pin_oe), 32'h0);
    check(32'(pin_out), 32'h2A);
    apb(1'b0, ssp_pkg::OFS_GPIO_IN, 32'h0);
    check(rd_q, 32'h2A);
    stop_req <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(pin_oe), 32'h3F);
    // Synchronous mode, device clocks, three transmit lanes and receive
    gpio_en <= 6'h00;
    rx_word <= 8'h5C;
    apb(1'b1, ssp_pkg::OFS_PORT_CTL, 32'h3F);
    apb(1'b1, ssp_pkg::OFS_TX1, 32'h96);
    apb(1'b1, ssp_pkg::OFS_TX2, 32'h3C);
    apb(1'b1, ssp_pkg::OFS_TX0, 32'hA5);
    apb(1'b1, ssp_pkg::OFS_SER_CFG, 32'h0000_10FF);
    wait_frame();
    check(32'(got_tx), 32'hA5);
    check(32'(got_a), 32'h96);
    check(32'(got_b), 32'h3C);
    check(32'(pin_oe), 32'h2F);
    repeat (4) @(posedge clk);
    apb(1'b0, ssp_pkg::OFS_STATUS, 32'h0);
    check(rd_q & 32'h3, 32'h2);
    apb(1'b0, ssp_pkg::OFS_RX, 32'h0);
    check(rd_q, 32'h5C);
    // Serial flags on both control pins, every value
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, ssp_pkg::OFS_SER_CFG, 32'h0000_1019 | (32'(f) << 8));
      @(posedge clk);
      check(32'({pin_oe[1:0], pin_out[1:0]}), 32'(4'hC | f));
    end
    // Asynchronous mode: control pins carry receive clock and sync
    apb(1'b1, ssp_pkg::OFS_SER_CFG, 32'h0000_109E);
    n_tog = 0;
    repeat (12) begin
      @(posedge clk);
      check(32'({pin_out[1:0], pin_oe[1:0]}),
            32'({pin_out[2], pin_out[3], 2'h3}));
      if (n_checks > 0 && pin_out[0] !== last0) n_tog++;
      last0 = pin_out[0];
    end
    // Receive clock pin must really toggle: div 4 gives two edges in this window
    check(32'(n_tog >= 2), 32'h1);
    // Far party makes clock and frame sync
    ext_mode <= 1'b1;
    rx_word  <= 8'hC3;
    apb(1'b1, ssp_pkg::OFS_SER_CFG, 32'h0000_1081);
    apb(1'b1, ssp_pkg::OFS_TX0, 32'h5A);
    far_u.ext_frame();
    check(32'(got_tx), 32'h5A);
    check(32'(pin_oe[3:2]), 32'h0);
    repeat (4) @(posedge clk);
    apb(1'b0, ssp_pkg::OFS_RX, 32'h0);
    check(rd_q, 32'hC3);
    // Reset in mid-run returns all pins to inputs
    rstn <= 1'b0;
    @(posedge clk);
    check(32'(pin_oe), 32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'(pin_oe), 32'h0);
    apb(1'b0, ssp_pkg::OFS_PORT_CTL, 32'h0);
    check(rd_q, 32'h0);
    apb(1'b0, ssp_pkg::OFS_SER_CFG, 32'h0);
    check(rd_q, 32'h0000_1000);
    wrap_up();
  end
endmodule
